// ==== hdl/rtc_twi_pkg.sv ====
package rtc_twi_pkg;

  // control codes, seven bits without the direction bit
  localparam logic [6:0] CODE_MEM      = 7'h6F;  // clock registers and sram
  localparam logic [6:0] CODE_ID       = 7'h57;  // identifier store

  // highest implemented address of each space
  localparam logic [7:0] MEM_ADDR_LAST = 8'h5F;
  localparam logic [7:0] ID_ADDR_LAST  = 8'h07;

  // reset values and bits per byte
  localparam logic [7:0] ADDR_RST      = 8'h00;
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [3:0] BITS_RST      = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // clock rates
  localparam int CORE_CLK_HZ          = 50_000_000;
  localparam int LINK_CLK_PERIOD_NS   = 80;

  // input_glitch_filter_width: spikes shorter than this are dropped
  localparam int GLITCH_NS      = 50;
  localparam int GLITCH_CYC_RAW =
    (GLITCH_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
  localparam int GLITCH_CYC     = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
  localparam int GLITCH_CNT_W   = 4;

  // identifier programming cycle, longest time rounds down
  localparam int PROG_MS        = 5;
  localparam int PROG_CYC       = PROG_MS * (CORE_CLK_HZ / 1000);
  localparam int PROG_CNT_W     = 24;

  // link side engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RNEXT
  } link_state_t;

endpackage

// ==== hdl/rtc_two_wire_slave_port.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: master starts transfers only on idle bus
// RQ2: both lines high means bus idle
// RQ3: data falls, clock high: start condition
// RQ4: data rises, clock high: stop condition
// RQ5: data changes only while clock low
// RQ6: one bit per clock, sampled high
// RQ7: any byte count between start, stop
// RQ8: device is slave, never makes conditions
// RQ9: master chooses read or write direction
// RQ10: acknowledge every byte written to device; code refuses bytes past 0x5F, or past 0x07 in the identifier store
// RQ11: master gives ninth clock for acknowledge
// RQ12: acknowledge low through whole ninth high
// RQ13: master withholds acknowledge after last read
// RQ14: release data line after master no-acknowledge
// RQ15: identifier not acknowledged while programming
// RQ16: programming cycle ends within 5 ms
// RQ17: ignore line spikes under 50 ns
// RQ18: code 1101111 selects clock and sram
// RQ19: code 1010111 selects unlocked identifier store
// RQ20: last bit direction; address follows msb first
// RQ21: no-acknowledge address beyond 0x5F
// RQ22: lines synchronised before condition detection
module rtc_two_wire_slave_port
  import rtc_twi_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC  // programming time in core cycles
) (
  input  wire logic       core_clk_in,     // core clock, 50 MHz
  input  wire logic       rstn_in,         // sync reset, active low
  input  wire logic       link_clk_in,     // link sampling clock
  input  wire logic       scl_in,          // serial clock pin
  input  wire logic       sda_in,          // serial data pin level
  output logic            sda_out,         // serial data drive value
  output logic            sda_oe_out,      // serial data drive enable
  output logic [7:0]      mem_addr_out,    // storage address
  output logic [7:0]      mem_wdata_out,   // storage write data
  output logic            mem_wr_out,      // storage write strobe
  output logic            mem_rd_out,      // storage read strobe
  output logic            mem_id_sel_out,  // 1: identifier store
  input  wire logic [7:0] mem_rdata_in,    // storage read data
  input  wire logic       id_unlock_in,    // identifier store unlocked
  output logic            id_busy_out      // programming cycle running
);

  import rtc_twi_pkg::*;

  // ---------------- link domain ----------------
  logic        lrst_meta;    // reset synchroniser first stage
  logic        link_rstn;    // link domain reset
  logic        scl_f;        // filtered clock line
  logic        sda_f;        // filtered data line
  logic        scl_d;        // previous clock sample
  logic        sda_d;        // previous data sample
  logic [1:0]  lvl_meta;     // level synchroniser first stage
  logic [1:0]  lvl_sync;     // {unlock, busy} in link domain
  link_state_t state;        // engine state
  link_state_t ack_next;     // state after acknowledge slot
  logic [3:0]  bit_cnt;      // bits moved in current byte
  logic [7:0]  shreg;        // shift register
  logic [7:0]  addr;         // current byte address
  logic [7:0]  wdata;        // byte handed to core side
  logic        id_sel;       // identifier space selected
  logic        id_wrote;     // identifier write since last stop
  logic        oe;           // data line pulled low
  logic        wr_tgl;       // write request toggle
  logic        rd_tgl;       // read request toggle
  logic        prog_tgl;     // programming start toggle
  logic        drv_zero;     // constant drive value flop

  link_state_t next_state;
  link_state_t next_ack_next;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  next_shreg;
  logic [7:0]  next_addr;
  logic [7:0]  next_wdata;
  logic        next_id_sel;
  logic        next_id_wrote;
  logic        next_oe;
  logic        next_wr_tgl;
  logic        next_rd_tgl;
  logic        next_prog_tgl;

  logic        scl_rise;     // clock line rose
  logic        scl_fall;     // clock line fell
  logic        start_ev;     // start condition seen
  logic        stop_ev;      // stop condition seen
  logic [7:0]  last_addr;    // limit of selected space
  logic [7:0]  rd_byte;      // byte held by core side
  logic [7:0]  mem_rdata_hold;  // core byte for link side

  // link domain reset from core reset
  always_ff @(posedge link_clk_in) begin
    lrst_meta <= rstn_in;
    link_rstn <= lrst_meta;
  end

  // deglitch and synchronise both bus lines
  twi_line_filter u_scl_filt (
    .clk_in   (link_clk_in),
    .rstn_in  (link_rstn),
    .line_in  (scl_in),  // [RQ17] [RQ22]
    .line_out (scl_f)
  );

  twi_line_filter u_sda_filt (
    .clk_in   (link_clk_in),
    .rstn_in  (link_rstn),
    .line_in  (sda_in),  // [RQ17] [RQ22]
    .line_out (sda_f)
  );

  // levels from core side into link domain
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      lvl_meta <= 2'h0;
      lvl_sync <= 2'h0;
    end else begin
      lvl_meta <= {id_unlock_in, id_busy_out};
      lvl_sync <= lvl_meta;
    end
  end

  // edge and condition decode from filtered lines
  always_comb begin
    scl_rise  = scl_f & ~scl_d;
    scl_fall  = ~scl_f & scl_d;
    start_ev  = scl_f & scl_d & sda_d & ~sda_f;  // [RQ3] [RQ5]
    stop_ev   = scl_f & scl_d & ~sda_d & sda_f;  // [RQ4] [RQ5]
    last_addr = id_sel ? ID_ADDR_LAST : MEM_ADDR_LAST;
    rd_byte   = mem_rdata_hold;
  end

  // engine next-state logic
  always_comb begin
    next_state    = state;
    next_ack_next = ack_next;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_addr     = addr;
    next_wdata    = wdata;
    next_id_sel   = id_sel;
    next_id_wrote = id_wrote;
    next_oe       = oe;
    next_wr_tgl   = wr_tgl;
    next_rd_tgl   = rd_tgl;
    next_prog_tgl = prog_tgl;
    if (stop_ev) begin
      // back to idle; program identifier bytes written
      next_state = ST_IDLE;  // [RQ2] [RQ4]
      next_oe    = 1'b0;
      if (id_wrote) begin
        next_prog_tgl = ~prog_tgl;  // [RQ16]
        next_id_wrote = 1'b0;
      end
    end else if (start_ev) begin
      // new or repeated start, expect a control byte
      next_state   = ST_CTRL;  // [RQ3]
      next_bit_cnt = BITS_RST;
      next_oe      = 1'b0;
    end else begin
      case (state)
        ST_CTRL, ST_ADDR, ST_WDATA: begin
          if (scl_rise && bit_cnt < BITS_PER_BYTE) begin
            // one bit per pulse, msb first
            next_shreg   = {shreg[6:0], sda_f};  // [RQ6] [RQ20]
            next_bit_cnt = bit_cnt + 1'b1;
          end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            next_bit_cnt = BITS_RST;
            next_state   = ST_IDLE;  // default: no acknowledge
            if (state == ST_CTRL) begin
              if (shreg[7:1] == CODE_MEM) begin
                next_id_sel = 1'b0;
                next_oe     = 1'b1;  // [RQ18] [RQ10]
                next_state  = ST_ACK;
              end else if (shreg[7:1] == CODE_ID && lvl_sync[1]
                           && !lvl_sync[0]) begin
                next_id_sel = 1'b1;
                next_oe     = 1'b1;  // [RQ19] [RQ15]
                next_state  = ST_ACK;
              end
              // direction follows the last control bit
              if (shreg[0]) begin
                next_ack_next = ST_RDATA;  // [RQ9] [RQ20]
                next_rd_tgl   = next_oe ? ~rd_tgl : rd_tgl;
              end else begin
                next_ack_next = ST_ADDR;
              end
            end else if (state == ST_ADDR) begin
              if (shreg <= last_addr) begin
                next_addr     = shreg;
                next_oe       = 1'b1;  // [RQ10]
                next_state    = ST_ACK;
                next_ack_next = ST_WDATA;
              end  // out of range: left released [RQ21]
            end else begin
              if (addr <= last_addr) begin
                // hand byte to core, advance address
                next_wdata    = shreg;
                next_wr_tgl   = ~wr_tgl;
                next_id_wrote = id_wrote | id_sel;
                next_addr     = addr + 1'b1;  // [RQ7]
                next_oe       = 1'b1;  // [RQ10]
                next_state    = ST_ACK;
                next_ack_next = ST_WDATA;
              end
            end
          end
        end
        ST_ACK: begin
          // hold low through the ninth pulse; on its fall release, or drive bit 7 when reading
          if (scl_fall) begin
            next_bit_cnt = BITS_RST;  // [RQ12] [RQ11]
            if (ack_next == ST_RDATA) begin
              next_shreg = rd_byte;
              next_oe    = ~rd_byte[7];  // [RQ5]
              next_state = ST_RDATA;
            end else begin
              next_oe    = 1'b0;
              next_state = ack_next;
            end
          end
        end
        ST_RDATA: begin
          // drive next bit just after each clock fall
          if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              next_oe    = 1'b0;  // release for master acknowledge
              next_state = ST_RACK;
            end else begin
              next_oe      = ~shreg[6];  // [RQ6] [RQ5]
              next_shreg   = {shreg[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 1'b1;
            end
          end
        end
        ST_RACK: begin
          // sample master acknowledge on ninth pulse
          if (scl_rise) begin
            if (!sda_f) begin
              next_addr   = (addr >= last_addr) ? ADDR_RST
                                                : addr + 1'b1;
              next_rd_tgl = ~rd_tgl;  // fetch following byte
              next_state  = ST_RNEXT;
            end else begin
              next_state = ST_IDLE;  // [RQ13] [RQ14]
            end
          end
        end
        ST_RNEXT: begin
          // first bit of next byte after ninth pulse ends
          if (scl_fall) begin
            next_shreg   = rd_byte;
            next_oe      = ~rd_byte[7];
            next_bit_cnt = BITS_RST;
            next_state   = ST_RDATA;
          end
        end
        default: begin
          next_oe = 1'b0;  // idle never drives [RQ8] [RQ1]
        end
      endcase
    end
  end

  // engine registers
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      state    <= ST_IDLE;
      ack_next <= ST_IDLE;
      bit_cnt  <= BITS_RST;
      shreg    <= BYTE_RST;
      addr     <= ADDR_RST;
      wdata    <= BYTE_RST;
      id_sel   <= 1'b0;
      id_wrote <= 1'b0;
      oe       <= 1'b0;
      wr_tgl   <= 1'b0;
      rd_tgl   <= 1'b0;
      prog_tgl <= 1'b0;
      drv_zero <= 1'b0;
    end else begin
      scl_d    <= scl_f;
      sda_d    <= sda_f;
      state    <= next_state;
      ack_next <= next_ack_next;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      addr     <= next_addr;
      wdata    <= next_wdata;
      id_sel   <= next_id_sel;
      id_wrote <= next_id_wrote;
      oe       <= next_oe;
      wr_tgl   <= next_wr_tgl;
      rd_tgl   <= next_rd_tgl;
      prog_tgl <= next_prog_tgl;
      drv_zero <= 1'b0;
    end
  end

  // open drain: value always low, enable pulls the line
  always_comb begin
    sda_out    = drv_zero;
    sda_oe_out = oe;
  end

  // ---------------- core domain ----------------
  logic [2:0]            tgl_meta;        // toggle sync first stage
  logic [2:0]            tgl_sync;        // toggle sync second stage
  logic [2:0]            tgl_last;        // for toggle edge detect
  logic [PROG_CNT_W-1:0] prog_cnt;        // programming time left
  logic [2:0]            tgl_ev;          // {prog, rd, wr} events
  logic [7:0]            next_maddr;
  logic [7:0]            next_mwdata;
  logic                  next_mwr;
  logic                  next_mrd;
  logic                  next_msel;
  logic [7:0]            next_hold;
  logic [PROG_CNT_W-1:0] next_prog_cnt;
  logic                  next_busy;

  // strobes and programming timer
  always_comb begin
    tgl_ev        = tgl_sync ^ tgl_last;
    next_maddr    = mem_addr_out;
    next_mwdata   = mem_wdata_out;
    next_msel     = mem_id_sel_out;
    next_mwr      = 1'b0;
    next_mrd      = 1'b0;
    next_hold     = mem_rd_out ? mem_rdata_in : mem_rdata_hold;
    next_prog_cnt = prog_cnt;
    next_busy     = id_busy_out;
    // link fields are stable for many cycles around each toggle
    if (tgl_ev[0]) begin
      next_maddr  = addr - 1'b1;  // address already advanced
      next_mwdata = wdata;
      next_msel   = id_sel;
      next_mwr    = 1'b1;
    end else if (tgl_ev[1]) begin
      next_maddr = addr;
      next_msel  = id_sel;
      next_mrd   = 1'b1;
    end
    if (tgl_ev[2]) begin
      next_busy     = 1'b1;  // [RQ16]
      next_prog_cnt = PROG_CNT_W'(PROG_CYCLES - 1);
    end else if (id_busy_out) begin
      if (prog_cnt == '0) begin
        next_busy = 1'b0;
      end else begin
        next_prog_cnt = prog_cnt - 1'b1;
      end
    end
  end

  // core registers
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      tgl_meta       <= 3'h0;
      tgl_sync       <= 3'h0;
      tgl_last       <= 3'h0;
      mem_addr_out   <= ADDR_RST;
      mem_wdata_out  <= BYTE_RST;
      mem_wr_out     <= 1'b0;
      mem_rd_out     <= 1'b0;
      mem_id_sel_out <= 1'b0;
      mem_rdata_hold <= BYTE_RST;
      prog_cnt       <= '0;
      id_busy_out    <= 1'b0;
    end else begin
      tgl_meta       <= {prog_tgl, rd_tgl, wr_tgl};
      tgl_sync       <= tgl_meta;
      tgl_last       <= tgl_sync;
      mem_addr_out   <= next_maddr;
      mem_wdata_out  <= next_mwdata;
      mem_wr_out     <= next_mwr;
      mem_rd_out     <= next_mrd;
      mem_id_sel_out <= next_msel;
      mem_rdata_hold <= next_hold;
      prog_cnt       <= next_prog_cnt;
      id_busy_out    <= next_busy;
    end
  end

endmodule

// ==== hdl/twi_line_filter.sv ====
`timescale 1ns/1ps
// two-flop synchroniser followed by a stability filter
module twi_line_filter
  import rtc_twi_pkg::*;
(
  input  wire logic clk_in,   // link sampling clock
  input  wire logic rstn_in,  // link domain reset, active low
  input  wire logic line_in,  // raw bus line
  output logic      line_out  // synchronised, deglitched line
);

  localparam logic [GLITCH_CNT_W-1:0] LIMIT = GLITCH_CNT_W'(GLITCH_CYC);

  logic                    meta;       // first synchroniser stage
  logic                    stable;     // second synchroniser stage
  logic [GLITCH_CNT_W-1:0] cnt;        // samples differing from output
  logic [GLITCH_CNT_W-1:0] next_cnt;
  logic                    next_line;

  // output follows only after the new level held for LIMIT+1 samples
  always_comb begin
    next_cnt  = '0;
    next_line = line_out;
    if (stable != line_out) begin
      if (cnt == LIMIT) begin
        next_line = stable;  // level held long enough
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // register stages; idle bus level is high
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta     <= 1'b1;
      stable   <= 1'b1;
      cnt      <= '0;
      line_out <= 1'b1;
    end else begin
      meta     <= line_in;
      stable   <= meta;
      cnt      <= next_cnt;
      line_out <= next_line;
    end
  end

endmodule

// ==== verification/rtc_twi_port_assertions.sv ====
`timescale 1ns/1ps
// watches the slave port at its pins and storage strobes
module rtc_twi_port_checker
  import rtc_twi_pkg::*;
#(
  parameter int PROG_CYCLES = 200  // programming time, core cycles
) (
  input wire logic       core_clk_in,     // core clock
  input wire logic       rstn_in,         // reset, active low
  input wire logic       link_clk_in,     // link sampling clock
  input wire logic       scl_in,          // bus clock pin
  input wire logic       sda_out,         // data drive value
  input wire logic       sda_oe_out,      // data drive enable
  input wire logic [7:0] mem_addr_out,    // storage address
  input wire logic       mem_wr_out,      // write strobe
  input wire logic       mem_rd_out,      // read strobe
  input wire logic       mem_id_sel_out,  // identifier select
  input wire logic       id_unlock_in,    // identifier unlocked
  input wire logic       id_busy_out      // programming running
);
  logic [23:0] busy_cnt;       // core cycles busy so far
  logic [23:0] next_busy_cnt;  // next count
  logic [3:0]  lrst_q;         // reset seen at link edges

  // count core cycles while programming runs
  always_comb begin
    next_busy_cnt = id_busy_out ? busy_cnt + 24'h000001 : 24'h000000;
    if (!rstn_in) begin
      next_busy_cnt = 24'h000000;  // cleared in reset
    end
  end
  always_ff @(posedge core_clk_in) begin
    busy_cnt <= next_busy_cnt;
  end

  // link checks wait for link reset
  always_ff @(posedge link_clk_in) begin
    lrst_q <= {lrst_q[2:0], rstn_in};
  end

  // two link samples with the bus clock high
  sequence s_clk_high;
    scl_in ##1 scl_in;
  endsequence
  // no read beside the write, then a cycle without write
  sequence s_wr_alone;
    !mem_rd_out ##1 !mem_wr_out;
  endsequence

  property p_oe_steady;
    @(posedge link_clk_in) disable iff (!rstn_in || lrst_q != 4'hF)
      s_clk_high |-> $stable(sda_oe_out);
  endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("data drive moved while clock high");

  property p_oe_moves_low;
    @(posedge link_clk_in) disable iff (!rstn_in || lrst_q != 4'hF)
      $changed(sda_oe_out) |-> !scl_in;
  endproperty
  a_oe_moves_low: assert property (p_oe_moves_low)
    else $error("data drive changed outside clock low");

  property p_drive_zero;
    @(posedge link_clk_in) disable iff (!rstn_in || lrst_q != 4'hF)
      sda_oe_out |-> (sda_out == 1'b0);
  endproperty
  a_drive_zero: assert property (p_drive_zero)
    else $error("data line driven high");

  property p_mem_range;
    @(posedge core_clk_in) disable iff (!rstn_in)
      mem_wr_out && !mem_id_sel_out |-> mem_addr_out <= MEM_ADDR_LAST;
  endproperty
  a_mem_range: assert property (p_mem_range)
    else $error("write beyond clock and sram space");

  property p_id_range;
    @(posedge core_clk_in) disable iff (!rstn_in)
      mem_wr_out && mem_id_sel_out |->
        mem_addr_out <= ID_ADDR_LAST && id_unlock_in;
  endproperty
  a_id_range: assert property (p_id_range)
    else $error("identifier write out of range or locked");

  property p_id_idle;
    @(posedge core_clk_in) disable iff (!rstn_in)
      mem_wr_out && mem_id_sel_out |-> !id_busy_out;
  endproperty
  a_id_idle: assert property (p_id_idle)
    else $error("identifier write while programming");

  property p_busy_len;
    @(posedge core_clk_in) disable iff (!rstn_in)
      $fell(id_busy_out) |-> busy_cnt == 24'(PROG_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming time wrong");

  property p_busy_cap;
    @(posedge core_clk_in) disable iff (!rstn_in)
      id_busy_out |-> busy_cnt < 24'(PROG_CYCLES);
  endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("programming overran");

  property p_wr_single;
    @(posedge core_clk_in) disable iff (!rstn_in)
      mem_wr_out |-> s_wr_alone;
  endproperty
  a_wr_single: assert property (p_wr_single)
    else $error("write strobe not a lone pulse");

  property p_rd_single;
    @(posedge core_clk_in) disable iff (!rstn_in)
      mem_rd_out |=> !mem_rd_out;
  endproperty
  a_rd_single: assert property (p_rd_single)
    else $error("read strobe longer than one cycle");
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import rtc_twi_pkg::*;
  localparam int PROG_SIM = 5000;  // shortened programming time
  logic       core_clk;     // core clock
  logic       link_clk;     // link sampling clock
  logic       rstn;         // reset, active low
  logic       scl;          // bus clock
  logic       sda;          // resolved data line
  logic       sda_drv;      // device drive value
  logic       sda_oe;       // device pulls data low
  logic       m_low;        // master pulls data low
  logic       id_unlock;    // identifier unlocked
  logic [7:0] maddr;        // storage address
  logic [7:0] mwdata;       // storage write data
  logic [7:0] mrdata;       // storage read data
  logic       mwr;          // write strobe
  logic       mrd;          // read strobe
  logic       msel;         // identifier select
  logic       busy;         // programming running
  logic [7:0] mem [256];    // clock and sram stand-in
  logic [7:0] id_mem [8];   // identifier stand-in
  int         mismatches;   // failed comparisons
  int         checks_done;  // comparisons made
  int         cycles = 0;   // core cycles run

  // clocks: core 20 ns, link 80 ns with an offset phase
  always #10 core_clk = ~core_clk;
  initial begin
    #3;
    forever #40 link_clk = ~link_clk;
  end
  // open drain data line with pull-up
  assign sda = ~(sda_oe | m_low);
  // storage stand-in, read without delay
  assign mrdata = msel ? id_mem[maddr[2:0]] : mem[maddr];
  always @(posedge core_clk) begin
    if (mwr && msel) begin
      id_mem[maddr[2:0]] <= mwdata;
    end else if (mwr) begin
      mem[maddr] <= mwdata;
    end
  end

  rtc_two_wire_slave_port #(.PROG_CYCLES(PROG_SIM)) dut (
    .core_clk_in(core_clk), .rstn_in(rstn), .link_clk_in(link_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
    .mem_addr_out(maddr), .mem_wdata_out(mwdata), .mem_wr_out(mwr),
    .mem_rd_out(mrd), .mem_id_sel_out(msel), .mem_rdata_in(mrdata),
    .id_unlock_in(id_unlock), .id_busy_out(busy));
  twi_master_model m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // send a byte and judge the acknowledge
  task automatic put(input logic [7:0] d, input logic exp);
    logic a;
    m.send_byte(d, 1'b0, a);
    check({7'h00, a}, {7'h00, exp});
  endtask
  task automatic ctl(input logic [7:0] d, input logic exp);
    m.start();
    put(d, exp);
  endtask
  // write up to the end of the space, one byte past it
  task automatic test_write();
    logic a;
    ctl({CODE_MEM, 1'b0}, 1'b1);
    put(8'h5E, 1'b1);
    m.send_byte(8'hC3, 1'b1, a);
    check({7'h00, a}, 8'h01);
    put(8'h3C, 1'b1);
    put(8'h77, 1'b0);
    m.stop();
    check(mem[8'h5E], 8'hC3);
    check(mem[8'h5F], 8'h3C);
  endtask
  // read across the wrap, end with no acknowledge
  task automatic test_read();
    logic [7:0] d;
    ctl({CODE_MEM, 1'b0}, 1'b1);
    put(8'h5F, 1'b1);
    ctl({CODE_MEM, 1'b1}, 1'b1);
    m.recv_byte(1'b0, d);
    check(d, 8'h3C);
    m.recv_byte(1'b1, d);
    check(d, 8'hA5);
    repeat (20) @(posedge core_clk);
    check({7'h00, sda_oe}, 8'h00);
    m.stop();
  endtask
  // refused address and foreign code
  task automatic test_refuse();
    ctl({CODE_MEM, 1'b0}, 1'b1);
    put(8'h60, 1'b0);
    m.stop();
    ctl(8'hA0, 1'b0);
    m.stop();
  endtask
  // identifier store: lock, write, polling while programming
  task automatic test_ident();
    int n;
    ctl({CODE_ID, 1'b0}, 1'b0);
    m.stop();
    @(posedge core_clk);
    id_unlock <= 1'b1;
    ctl({CODE_ID, 1'b0}, 1'b1);
    put(8'h07, 1'b1);
    put(8'h9B, 1'b1);
    m.stop();
    check(id_mem[7], 8'h9B);
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    check({7'h00, busy}, 8'h01);
    ctl({CODE_ID, 1'b0}, 1'b0);
    m.stop();
    ctl({CODE_MEM, 1'b0}, 1'b1);
    m.stop();
    while (busy !== 1'b0 && n < PROG_SIM + 100) begin
      @(posedge core_clk);
      n++;
    end
    check({7'h00, busy}, 8'h00);
    ctl({CODE_ID, 1'b0}, 1'b1);
    m.stop();
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    core_clk = 1'b0;
    link_clk = 1'b0;
    rstn = 1'b0;
    id_unlock = 1'b0;
    mismatches = 0;
    checks_done = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    for (int i = 0; i < 8; i++) id_mem[i] = 8'h00;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge core_clk);
    test_write();
    test_read();
    test_refuse();
    test_ident();
    finish_test();
  end
endmodule

bind rtc_two_wire_slave_port rtc_twi_port_checker #(
  .PROG_CYCLES(PROG_CYCLES)) chk (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .link_clk_in(link_clk_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .mem_addr_out(mem_addr_out),
  .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out),
  .mem_id_sel_out(mem_id_sel_out), .id_unlock_in(id_unlock_in),
  .id_busy_out(id_busy_out));

// ==== verification/twi_master_model.sv ====
`timescale 1ns/1ps
// bus master stand-in: owns the clock, pulls data low only
module twi_master_model #(
  parameter int HALF_NS = 1600  // half of one bus clock period
) (
  output logic      scl_out,      // bus clock
  output logic      sda_low_out,  // high pulls data low
  input  wire logic sda_in        // resolved data line
);
  initial begin
    scl_out     = 1'b1;  // idle bus, both lines high
    sda_low_out = 1'b0;
  end
  // start on an idle or held bus, ends with clock low
  task automatic start();
    #(HALF_NS / 2);
    sda_low_out = 1'b0;
    #(HALF_NS / 2);
    scl_out = 1'b1;
    #(HALF_NS);
    sda_low_out = 1'b1;  // data falls, clock high
    #(HALF_NS);
    scl_out = 1'b0;
  endtask
  // stop, then bus free time before anything new
  task automatic stop();
    #(HALF_NS / 2);
    sda_low_out = 1'b1;
    #(HALF_NS / 2);
    scl_out = 1'b1;
    #(HALF_NS);
    sda_low_out = 1'b0;  // data rises, clock high
    #(HALF_NS * 2);  // idle gap
  endtask
  // one clock pulse; optional short spike on the low clock
  task automatic bit_cycle(input logic b, input logic spike,
                           output logic seen);
    #(HALF_NS / 2);
    sda_low_out = !b;  // data moves only with clock low
    #(HALF_NS / 4);
    if (spike) begin
      scl_out = 1'b1;  // 40 ns spike
      #40;
      scl_out = 1'b0;
    end
    #(HALF_NS / 4);
    scl_out = 1'b1;
    #(HALF_NS / 2);
    seen = sda_in;
    #(HALF_NS / 2);
    scl_out = 1'b0;
  endtask
  // eight bits msb first, then the ninth pulse for acknowledge
  task automatic send_byte(input logic [7:0] d, input logic spike,
                           output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], spike && i == 4, s);
    end
    bit_cycle(1'b1, 1'b0, s);  // acknowledge pulse
    ack = !s;
  endtask
  // read eight bits, then acknowledge or withhold it
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, 1'b0, s);
      d[i] = s;
    end
    bit_cycle(last, 1'b0, s);  // no acknowledge on last
  endtask
endmodule
